// ==== src/fpc_pkg.sv ====
/*
 Constants, register map and types for the fault-protection configuration and status block.
 Assumes a 200 MHz reference clock and an I2C host reaching the registers by byte address.
*/
package fpc_pkg;
	// Timing
	localparam int CLK_MHZ           = 200;
	localparam int AUTO_CLEAR_US     = 30;
	localparam int RECOVERY_BASE_MS  = 2;
	localparam int AUTO_CLEAR_CYC    = AUTO_CLEAR_US * CLK_MHZ;
	localparam int RECOVERY_BASE_CYC = RECOVERY_BASE_MS * 1000 * CLK_MHZ;

	// Register offsets
	localparam logic [7:0] OFS_PG_OC  = 8'h0B;
	localparam logic [7:0] OFS_FM_UV  = 8'h0C;
	localparam logic [7:0] OFS_OV     = 8'h0D;
	localparam logic [7:0] OFS_THERM  = 8'h0E;
	localparam logic [7:0] OFS_STATUS = 8'h0F;
	localparam logic [7:0] OFS_ID     = 8'h10;

	// Reset values
	localparam logic [7:0] RST_PG_OC = 8'h00;
	localparam logic [7:0] RST_FM_UV = 8'h00;
	localparam logic [7:0] RST_OV    = 8'h00;
	localparam logic [3:0] RST_THERM = 4'h0;

	// Field positions
	localparam int PG_UHYS_BIT   = 7;
	localparam int PG_UPPER_BIT  = 6;
	localparam int PG_LHYS_BIT   = 5;
	localparam int PG_LOWER_BIT  = 4;
	localparam int OC_CNT_LSB    = 2;
	localparam int OC_RESP_LSB   = 0;
	localparam int FLT_LATCH_BIT = 7;
	localparam int REC_DLY_LSB   = 5;
	localparam int UV_THR_BIT    = 4;
	localparam int UV_CNT_LSB    = 2;
	localparam int UV_RESP_LSB   = 0;
	localparam int FB_CONN_BIT   = 1;
	localparam int OV_RESP_BIT   = 0;
	localparam int THS_HYS_LSB   = 2;
	localparam int THS_TRIP_LSB  = 0;

	// Decoded thresholds, percent of reference or degrees C
	localparam logic [7:0] PCT_UPPER_LO = 8'h70;
	localparam logic [7:0] PCT_UPPER_HI = 8'h75;
	localparam logic [7:0] PCT_LOWER_LO = 8'h5A;
	localparam logic [7:0] PCT_LOWER_HI = 8'h55;
	localparam logic [7:0] PCT_HYS_LO   = 8'h04;
	localparam logic [7:0] PCT_HYS_HI   = 8'h06;
	localparam logic [7:0] PCT_UV_LO    = 8'h32;
	localparam logic [7:0] PCT_UV_HI    = 8'h4B;
	localparam logic [7:0] DEG_TRIP_0   = 8'h96;
	localparam logic [7:0] DEG_TRIP_1   = 8'hA0;
	localparam logic [7:0] DEG_TRIP_2   = 8'hAA;
	localparam logic [7:0] DEG_HYS_0    = 8'h19;
	localparam logic [7:0] DEG_HYS_1    = 8'h32;
	localparam logic [7:0] DEG_HYS_2    = 8'h4B;

	// Response codes and persistence count base
	localparam logic [1:0] RESP_RECOVER = 2'h0;
	localparam logic [1:0] RESP_LATCH   = 2'h1;
	localparam logic [2:0] COUNT_BASE_LOG2 = 3'h1;

	typedef enum logic [1:0] {
		PR_OFF   = 2'b00,
		PR_RUN   = 2'b01,
		PR_WAIT  = 2'b10,
		PR_LATCH = 2'b11
	} fpc_prot_t;

	typedef enum logic [3:0] {
		I2_IDLE  = 4'b0000,
		I2_ADDR  = 4'b0001,
		I2_AACK  = 4'b0010,
		I2_REG   = 4'b0011,
		I2_RACK  = 4'b0100,
		I2_WDATA = 4'b0101,
		I2_WACK  = 4'b0110,
		I2_RDATA = 4'b0111,
		I2_MACK  = 4'b1000
	} fpc_i2c_t;
endpackage

// ==== src/fpc_cnt_if.sv ====
/*
 Link between the protection controller and one fault persistence counter.
 Assumes both ends run on the same reference clock.
*/
`timescale 1ns/10ps
interface fpc_cnt_if;
	logic       tick;
	logic       cond;
	logic       arm;
	logic [1:0] sel;
	logic       fault;

	modport ctrl (output tick, output cond, output arm, output sel, input fault);
	modport cnt  (input tick, input cond, input arm, input sel, output fault);
endinterface

// ==== src/fpc_fault_counter.sv ====
/*
 Counts consecutive switching periods of a fault condition and declares the fault.
 Assumes the tick is a one-cycle pulse per switching period.
*/
`timescale 1ns/10ps
module fpc_fault_counter #(
	parameter int WIDTH = 5
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	fpc_cnt_if.cnt    port_if
);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] target;
	logic [WIDTH-1:0] next_count;

	assign target     = {{(WIDTH-1){1'b0}}, 1'b1} << (3'(port_if.sel) + fpc_pkg::COUNT_BASE_LOG2);
	assign next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};

	// Restart on any cycle without the condition
	always_ff @(posedge ref_clk) begin
		if (rst || !port_if.arm || !port_if.cond) begin
			count         <= '0;
			port_if.fault <= 1'b0;
		end else if (port_if.tick && !port_if.fault) begin
			count <= next_count;
			if (next_count == target) begin
				port_if.fault <= 1'b1;
			end
		end
	end
endmodule

// ==== src/fpc_hold_timer.sv ====
/*
 Down-counter that gives a one-cycle done pulse a loaded number of cycles later.
 Assumes the loaded count is at least one.
*/
`timescale 1ns/10ps
module fpc_hold_timer (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        load,
	input  wire logic [31:0] cycles,
	output logic             done
);
	logic [31:0] left;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			left <= 32'h0;
			done <= 1'b0;
		end else if (load) begin
			left <= cycles;
			done <= 1'b0;
		end else begin
			done <= (left == 32'h1);
			if (left != 32'h0) begin
				left <= left - 32'h1;
			end
		end
	end
endmodule

// ==== src/fpc_top.sv ====
/*
 Fault-protection configuration and status registers with I2C access and protection control.
 Assumes analog comparators deliver synchronous condition levels and a switching-period tick.
*/
`timescale 1ns/10ps
module fpc_top #(
	parameter logic [6:0] DEV_ADDR           = 7'h20,
	parameter logic [4:0] MAKER_CODE         = 5'h01,
	parameter logic [2:0] VERSION_CODE       = 3'h1,
	parameter logic [1:0] OTP_PAGES          = 2'h0,
	parameter int         AUTO_CLEAR_CYCLES  = fpc_pkg::AUTO_CLEAR_CYC,
	parameter int         RECOVERY_BASE_CYCLES = fpc_pkg::RECOVERY_BASE_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       en,
	input  wire logic       sw_tick,
	input  wire logic       soft_start,
	input  wire logic       oc_cond,
	input  wire logic       uv_cond,
	input  wire logic       vout_ov_cond,
	input  wire logic       vin_ov_cond,
	input  wire logic       ot_cond,
	input  wire logic       output_ok_cond,
	input  wire logic [2:0] tj_range,
	output logic            switch_en,
	output logic            restart_req,
	output logic            hiccup_active,
	output logic            latched_off,
	output logic            feedback_connect_sel,
	output logic [7:0]      pg_rise_pct,
	output logic [7:0]      pg_rise_hys_pct,
	output logic [7:0]      pg_fall_pct,
	output logic [7:0]      pg_fall_hys_pct,
	output logic [7:0]      uv_trip_pct,
	output logic [7:0]      thermal_trip_degc,
	output logic [7:0]      thermal_hys_degc
);
	// Registers
	logic [7:0] power_good_overcurrent_config;
	logic [7:0] fault_mode_undervoltage_config;
	logic [7:0] overvoltage_config;
	logic [3:0] thermal_config;
	logic       output_ok_flag;
	logic [1:0] sticky_flag;
	logic [1:0] flag_cond;
	logic       input_overvoltage_flag;
	logic       overtemperature_flag;

	// I2C
	fpc_pkg::fpc_i2c_t i2c_st;
	logic       scl_q;
	logic       sda_q;
	logic       scl_rise;
	logic       scl_fall;
	logic       bus_start;
	logic       bus_stop;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] ptr;
	logic       rd_mode;
	logic       wr_stb;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;

	// Protection
	fpc_pkg::fpc_prot_t prot_st;
	fpc_pkg::fpc_prot_t next_prot_st;
	logic        wait_load;
	logic        wait_done;
	logic [31:0] wait_cycles;
	logic        uv_fault;
	logic        oc_fault;
	logic [1:0]  uv_resp;
	logic [1:0]  oc_resp;
	logic        fault_latch_sel;

	fpc_cnt_if oc_if ();
	fpc_cnt_if uv_if ();

	assign fault_latch_sel = fault_mode_undervoltage_config[fpc_pkg::FLT_LATCH_BIT];
	assign uv_resp = fault_mode_undervoltage_config[fpc_pkg::UV_RESP_LSB +: 2];
	assign oc_resp = power_good_overcurrent_config[fpc_pkg::OC_RESP_LSB +: 2];
	assign input_overvoltage_flag = sticky_flag[0];
	assign overtemperature_flag   = sticky_flag[1];
	assign flag_cond = {ot_cond, vin_ov_cond};

	function automatic logic [7:0] read_reg(input logic [7:0] a);
		case (a)
			fpc_pkg::OFS_PG_OC:  read_reg = power_good_overcurrent_config;
			fpc_pkg::OFS_FM_UV:  read_reg = fault_mode_undervoltage_config;
			fpc_pkg::OFS_OV:     read_reg = overvoltage_config;
			fpc_pkg::OFS_THERM:  read_reg = {1'b0, tj_range, thermal_config};
			fpc_pkg::OFS_STATUS: read_reg = {OTP_PAGES, output_ok_flag, input_overvoltage_flag,
				3'h0, overtemperature_flag};
			fpc_pkg::OFS_ID:     read_reg = {MAKER_CODE, VERSION_CODE};
			default:             read_reg = 8'h00;
		endcase
	endfunction

	// Bus conditions
	assign scl_rise  = scl_in && !scl_q;
	assign scl_fall  = !scl_in && scl_q;
	assign bus_start = scl_in && scl_q && sda_q && !sda_in;
	assign bus_stop  = scl_in && scl_q && !sda_q && sda_in;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	// I2C slave; sda_oe low pulls the line low
	always_ff @(posedge ref_clk) begin
		if (rst || bus_stop) begin
			i2c_st  <= fpc_pkg::I2_IDLE;
			sda_oe  <= 1'b1;
			sda_out <= 1'b0;
			bit_cnt <= 4'h0;
			shreg   <= 8'h00;
			rd_mode <= 1'b0;
			wr_stb  <= 1'b0;
			if (rst) begin
				ptr     <= 8'h00;
				wr_addr <= 8'h00;
				wr_data <= 8'h00;
			end
		end else if (bus_start) begin
			i2c_st  <= fpc_pkg::I2_ADDR;
			sda_oe  <= 1'b1;
			bit_cnt <= 4'h0;
			wr_stb  <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			unique case (i2c_st)
				fpc_pkg::I2_IDLE: begin
				end
				fpc_pkg::I2_ADDR, fpc_pkg::I2_REG, fpc_pkg::I2_WDATA: begin
					if (scl_rise) begin
						shreg   <= {shreg[6:0], sda_in};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == 4'h8) begin
						bit_cnt <= 4'h0;
						if (i2c_st == fpc_pkg::I2_ADDR) begin
							if (shreg[7:1] == DEV_ADDR) begin
								rd_mode <= shreg[0];
								sda_oe  <= 1'b0;
								i2c_st  <= fpc_pkg::I2_AACK;
							end else begin
								i2c_st <= fpc_pkg::I2_IDLE;
							end
						end else if (i2c_st == fpc_pkg::I2_REG) begin
							ptr    <= shreg;
							sda_oe <= 1'b0;
							i2c_st <= fpc_pkg::I2_RACK;
						end else begin
							wr_stb  <= 1'b1;
							wr_addr <= ptr;
							wr_data <= shreg;
							sda_oe  <= 1'b0;
							i2c_st  <= fpc_pkg::I2_WACK;
						end
					end
				end
				fpc_pkg::I2_AACK: begin
					if (scl_fall) begin
						if (rd_mode) begin
							shreg   <= read_reg(ptr);
							sda_oe  <= read_reg(ptr) >> 7 != 8'h00;
							bit_cnt <= 4'h1;
							i2c_st  <= fpc_pkg::I2_RDATA;
						end else begin
							sda_oe <= 1'b1;
							i2c_st <= fpc_pkg::I2_REG;
						end
					end
				end
				fpc_pkg::I2_RACK: begin
					if (scl_fall) begin
						sda_oe <= 1'b1;
						i2c_st <= fpc_pkg::I2_WDATA;
					end
				end
				fpc_pkg::I2_WACK: begin
					if (scl_fall) begin
						sda_oe <= 1'b1;
						ptr    <= ptr + 8'h01;
						i2c_st <= fpc_pkg::I2_WDATA;
					end
				end
				fpc_pkg::I2_RDATA: begin
					if (scl_fall) begin
						if (bit_cnt == 4'h8) begin
							sda_oe  <= 1'b1;
							bit_cnt <= 4'h0;
							i2c_st  <= fpc_pkg::I2_MACK;
						end else begin
							shreg   <= {shreg[6:0], 1'b0};
							sda_oe  <= shreg[6];
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
				end
				fpc_pkg::I2_MACK: begin
					if (scl_rise && sda_in) begin
						i2c_st <= fpc_pkg::I2_IDLE;
					end else if (scl_fall) begin
						ptr     <= ptr + 8'h01;
						shreg   <= read_reg(ptr + 8'h01);
						sda_oe  <= read_reg(ptr + 8'h01) >> 7 != 8'h00;
						bit_cnt <= 4'h1;
						i2c_st  <= fpc_pkg::I2_RDATA;
					end
				end
				default: begin
					i2c_st <= fpc_pkg::I2_IDLE;
				end
			endcase
		end
	end

	// Register writes; unmapped and read-only offsets ignore writes
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			power_good_overcurrent_config  <= fpc_pkg::RST_PG_OC;
			fault_mode_undervoltage_config <= fpc_pkg::RST_FM_UV;
			overvoltage_config             <= fpc_pkg::RST_OV;
			thermal_config                 <= fpc_pkg::RST_THERM;
		end else if (wr_stb) begin
			case (wr_addr)
				fpc_pkg::OFS_PG_OC: power_good_overcurrent_config  <= wr_data;
				fpc_pkg::OFS_FM_UV: fault_mode_undervoltage_config <= wr_data;
				fpc_pkg::OFS_OV:    overvoltage_config             <= wr_data;
				fpc_pkg::OFS_THERM: thermal_config                 <= wr_data[3:0];
				default: begin
				end
			endcase
		end
	end

	// Decoded thresholds for the analog side
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pg_rise_pct          <= fpc_pkg::PCT_UPPER_LO;
			pg_rise_hys_pct      <= fpc_pkg::PCT_HYS_LO;
			pg_fall_pct          <= fpc_pkg::PCT_LOWER_LO;
			pg_fall_hys_pct      <= fpc_pkg::PCT_HYS_LO;
			uv_trip_pct          <= fpc_pkg::PCT_UV_LO;
			thermal_trip_degc    <= fpc_pkg::DEG_TRIP_0;
			thermal_hys_degc     <= fpc_pkg::DEG_HYS_0;
			feedback_connect_sel <= 1'b0;
		end else begin
			pg_rise_pct <= power_good_overcurrent_config[fpc_pkg::PG_UPPER_BIT] ?
				fpc_pkg::PCT_UPPER_HI : fpc_pkg::PCT_UPPER_LO;
			pg_rise_hys_pct <= power_good_overcurrent_config[fpc_pkg::PG_UHYS_BIT] ?
				fpc_pkg::PCT_HYS_HI : fpc_pkg::PCT_HYS_LO;
			pg_fall_pct <= power_good_overcurrent_config[fpc_pkg::PG_LOWER_BIT] ?
				fpc_pkg::PCT_LOWER_HI : fpc_pkg::PCT_LOWER_LO;
			pg_fall_hys_pct <= power_good_overcurrent_config[fpc_pkg::PG_LHYS_BIT] ?
				fpc_pkg::PCT_HYS_HI : fpc_pkg::PCT_HYS_LO;
			uv_trip_pct <= fault_mode_undervoltage_config[fpc_pkg::UV_THR_BIT] ?
				fpc_pkg::PCT_UV_HI : fpc_pkg::PCT_UV_LO;
			case (thermal_config[fpc_pkg::THS_TRIP_LSB +: 2])
				2'h0:    thermal_trip_degc <= fpc_pkg::DEG_TRIP_0;
				2'h1:    thermal_trip_degc <= fpc_pkg::DEG_TRIP_1;
				default: thermal_trip_degc <= fpc_pkg::DEG_TRIP_2;
			endcase
			case (thermal_config[fpc_pkg::THS_HYS_LSB +: 2])
				2'h0:    thermal_hys_degc <= fpc_pkg::DEG_HYS_0;
				2'h1:    thermal_hys_degc <= fpc_pkg::DEG_HYS_1;
				default: thermal_hys_degc <= fpc_pkg::DEG_HYS_2;
			endcase
			feedback_connect_sel <= overvoltage_config[fpc_pkg::FB_CONN_BIT];
		end
	end

	// Status flags: output ok follows its condition; sticky flags: set wins, then auto-clear or hold until enable drops
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			output_ok_flag <= 1'b0;
		end else begin
			output_ok_flag <= output_ok_cond;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_flag
			logic [31:0] clr_cnt;
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					sticky_flag[gi] <= 1'b0;
					clr_cnt         <= 32'h0;
				end else if (flag_cond[gi]) begin
					sticky_flag[gi] <= 1'b1;
					clr_cnt         <= 32'h0;
				end else if (!en) begin
					sticky_flag[gi] <= 1'b0;
					clr_cnt         <= 32'h0;
				end else if (sticky_flag[gi] && !fault_latch_sel) begin
					if (clr_cnt == 32'(AUTO_CLEAR_CYCLES - 1)) begin
						sticky_flag[gi] <= 1'b0;
						clr_cnt         <= 32'h0;
					end else begin
						clr_cnt <= clr_cnt + 32'h1;
					end
				end
			end
		end
	endgenerate

	// Persistence counters
	assign oc_if.tick = sw_tick;
	assign oc_if.cond = oc_cond;
	assign oc_if.arm  = (prot_st == fpc_pkg::PR_RUN);
	assign oc_if.sel  = power_good_overcurrent_config[fpc_pkg::OC_CNT_LSB +: 2];
	assign uv_if.tick = sw_tick;
	assign uv_if.cond = uv_cond;
	assign uv_if.arm  = (prot_st == fpc_pkg::PR_RUN) && !soft_start;
	assign uv_if.sel  = fault_mode_undervoltage_config[fpc_pkg::UV_CNT_LSB +: 2];
	assign uv_fault   = uv_if.fault;
	assign oc_fault   = oc_if.fault && !uv_fault;

	fpc_fault_counter #(.WIDTH(5)) u_oc_cnt (
		.ref_clk (ref_clk),
		.rst     (rst),
		.port_if (oc_if.cnt)
	);

	fpc_fault_counter #(.WIDTH(5)) u_uv_cnt (
		.ref_clk (ref_clk),
		.rst     (rst),
		.port_if (uv_if.cnt)
	);

	assign wait_cycles = 32'(RECOVERY_BASE_CYCLES) <<
		fault_mode_undervoltage_config[fpc_pkg::REC_DLY_LSB +: 2];

	fpc_hold_timer u_wait (
		.ref_clk (ref_clk),
		.rst     (rst),
		.load    (wait_load),
		.cycles  (wait_cycles),
		.done    (wait_done)
	);

	// Protection response selection
	always_comb begin
		next_prot_st = prot_st;
		unique case (prot_st)
			fpc_pkg::PR_OFF: begin
				if (en) begin
					next_prot_st = fpc_pkg::PR_RUN;
				end
			end
			fpc_pkg::PR_RUN: begin
				if (uv_fault) begin
					if (uv_resp == fpc_pkg::RESP_RECOVER) begin
						next_prot_st = fpc_pkg::PR_WAIT;
					end else if (uv_resp == fpc_pkg::RESP_LATCH) begin
						next_prot_st = fpc_pkg::PR_LATCH;
					end
				end else if (oc_fault) begin
					if (oc_resp == fpc_pkg::RESP_RECOVER) begin
						next_prot_st = fpc_pkg::PR_WAIT;
					end else if (oc_resp == fpc_pkg::RESP_LATCH) begin
						next_prot_st = fpc_pkg::PR_LATCH;
					end
				end else if (vout_ov_cond) begin
					next_prot_st = overvoltage_config[fpc_pkg::OV_RESP_BIT] ?
						fpc_pkg::PR_LATCH : fpc_pkg::PR_WAIT;
				end
			end
			fpc_pkg::PR_WAIT: begin
				if (wait_done) begin
					next_prot_st = fpc_pkg::PR_RUN;
				end
			end
			fpc_pkg::PR_LATCH: begin
				next_prot_st = fpc_pkg::PR_LATCH;
			end
		endcase
		if (!en) begin
			next_prot_st = fpc_pkg::PR_OFF;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prot_st       <= fpc_pkg::PR_OFF;
			wait_load     <= 1'b0;
			hiccup_active <= 1'b0;
			restart_req   <= 1'b0;
			latched_off   <= 1'b0;
			switch_en     <= 1'b0;
		end else begin
			prot_st     <= next_prot_st;
			wait_load   <= (prot_st == fpc_pkg::PR_RUN) && (next_prot_st == fpc_pkg::PR_WAIT);
			restart_req <= (prot_st != fpc_pkg::PR_RUN) && (next_prot_st == fpc_pkg::PR_RUN);
			latched_off <= (next_prot_st == fpc_pkg::PR_LATCH);
			if (next_prot_st == fpc_pkg::PR_OFF) begin
				hiccup_active <= 1'b0;
			end else if (next_prot_st == fpc_pkg::PR_WAIT) begin
				hiccup_active <= 1'b1;
			end
			// Input over-voltage and over-temperature only pause switching
			switch_en <= (next_prot_st == fpc_pkg::PR_RUN) && !vin_ov_cond && !ot_cond;
		end
	end

	// Checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_upper_limit_map: assert property (
		pg_rise_pct == ($past(power_good_overcurrent_config[fpc_pkg::PG_UPPER_BIT]) ?
			fpc_pkg::PCT_UPPER_HI : fpc_pkg::PCT_UPPER_LO)) else $error("upper limit wrong");
	a_uv_blanked_soft: assert property (
		soft_start |=> !uv_if.fault) else $error("uv fault during soft start");
	a_uv_over_oc: assert property (
		prot_st == fpc_pkg::PR_RUN && uv_fault && oc_if.fault && uv_resp[1] && en
		|=> prot_st == fpc_pkg::PR_RUN) else $error("oc acted over uv");
	a_latch_holds_en: assert property (
		prot_st == fpc_pkg::PR_LATCH && en |=> prot_st == fpc_pkg::PR_LATCH)
		else $error("latch left without enable");
	a_vin_ov_pause: assert property (
		vin_ov_cond |=> !switch_en && !latched_off || prot_st == fpc_pkg::PR_LATCH)
		else $error("switching during input ov");
	a_flag_set_wins: assert property (
		vin_ov_cond |=> input_overvoltage_flag) else $error("input ov flag lost");
	a_flag_latched: assert property (
		fault_latch_sel && en && !ot_cond && overtemperature_flag ##1 fault_latch_sel && en
		|-> overtemperature_flag) else $error("latched flag cleared");
	a_counter_restart: assert property (
		!uv_cond |=> !uv_if.fault)
		else $error("uv count kept");
	a_wait_loads: assert property (
		prot_st == fpc_pkg::PR_RUN && next_prot_st == fpc_pkg::PR_WAIT |=> wait_load)
		else $error("off-time not started");
endmodule

// ==== bench/fpc_i2c_host.sv ====
/*
 I2C host model that reads and writes the fault-protection registers.
 Assumes the bench resolves SDA as an open-drain wire with a pull-up.
*/
`timescale 1ns/10ps
module fpc_i2c_host #(
	parameter logic [6:0] ADDR = 7'h20
) (
	input  wire logic ref_clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_drv
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic half(input logic c, input logic d);
		scl <= c;
		sda_drv <= d;
		repeat (4) @(posedge ref_clk);
	endtask
	// SDA only moves while SCL is low
	task automatic xbit(input logic d, output logic q);
		half(1'b0, sda_drv);
		half(1'b0, d);
		half(1'b1, d);
		q = sda_line;
	endtask
	task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			xbit(d[i], b);
			q[i] = b;
		end
		xbit(a, b);
		ack = ~b;
	endtask
	task automatic start();
		half(1'b0, sda_drv);
		half(1'b0, 1'b1);
		half(1'b1, 1'b1);
		half(1'b1, 1'b0);
	endtask
	task automatic stop();
		half(1'b0, sda_drv);
		half(1'b0, 1'b0);
		half(1'b1, 1'b0);
		half(1'b1, 1'b1);
	endtask
	// Ack reports the address phase
	task automatic wr(input logic [6:0] a7, input logic [7:0] r, input logic [7:0] d, output logic ack);
		logic [7:0] q;
		logic       k;
		start();
		xbyte({a7, 1'b0}, 1'b1, q, ack);
		if (ack) begin
			xbyte(r, 1'b1, q, k);
			xbyte(d, 1'b1, q, k);
		end
		stop();
	endtask
	task automatic rd(input logic [7:0] r, output logic [7:0] d);
		logic [7:0] q;
		logic       k;
		start();
		xbyte({ADDR, 1'b0}, 1'b1, q, k);
		xbyte(r, 1'b1, q, k);
		start();
		xbyte({ADDR, 1'b1}, 1'b1, q, k);
		xbyte(8'hFF, 1'b1, d, k);
		stop();
	endtask
endmodule

// ==== bench/tb.sv ====
/*
 Self-checking bench for the fault-protection register block.
 Assumes shortened auto-clear and recovery counts set at the instance.
*/
`timescale 1ns/10ps
module tb;
	localparam logic [4:0] MAKER = 5'h0A; // Arbitrary
	localparam logic [2:0] VER   = 3'h5;  // Arbitrary
	localparam logic [7:0] TRIP [4] = '{8'h96, 8'hA0, 8'hAA, 8'hAA};
	localparam logic [7:0] THYS [4] = '{8'h19, 8'h32, 8'h4B, 8'h4B};
	logic ref_clk = 1'b0, rst = 1'b1, en = 1'b1, sw_tick = 1'b0, soft_start = 1'b0;
	logic oc_cond = 1'b0, uv_cond = 1'b0, vout_ov_cond = 1'b0, vin_ov_cond = 1'b0;
	logic ot_cond = 1'b0, output_ok_cond = 1'b0, ack;
	logic [2:0] tj_range = 3'h5;
	logic scl, sda_drv, sda_out, sda_oe, switch_en, restart_req, hiccup_active, latched_off;
	logic feedback_connect_sel;
	logic [7:0] pg_rise_pct, pg_rise_hys_pct, pg_fall_pct, pg_fall_hys_pct, uv_trip_pct;
	logic [7:0] thermal_trip_degc, thermal_hys_degc, q;
	wire logic sda_line;
	int mismatches = 0, checks = 0, cyc = 0, restarts = 0;
	assign sda_line = sda_drv & (sda_oe | sda_out);
	always #2.5 ref_clk = ~ref_clk;
	fpc_i2c_host u_host (.ref_clk, .sda_line, .scl, .sda_drv);
	fpc_top #(.MAKER_CODE(MAKER), .VERSION_CODE(VER), .AUTO_CLEAR_CYCLES(20),
		.RECOVERY_BASE_CYCLES(50)) u_dut (.ref_clk, .rst, .scl_in(scl), .sda_in(sda_line),
		.sda_out, .sda_oe, .en, .sw_tick, .soft_start, .oc_cond, .uv_cond, .vout_ov_cond,
		.vin_ov_cond, .ot_cond, .output_ok_cond, .tj_range, .switch_en, .restart_req,
		.hiccup_active, .latched_off, .feedback_connect_sel, .pg_rise_pct, .pg_rise_hys_pct,
		.pg_fall_pct, .pg_fall_hys_pct, .uv_trip_pct, .thermal_trip_degc, .thermal_hys_degc);
	task automatic test_done();
		if (mismatches == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] r, input logic [7:0] d);
		u_host.wr(7'h20, r, d, ack);
	endtask
	task automatic rchk(input logic [7:0] r, input logic [7:0] exp);
		u_host.rd(r, q);
		chk(q, exp);
	endtask
	task automatic ticks(input int n, input int gap);
		repeat (n) begin
			sw_tick <= 1'b1;
			@(posedge ref_clk);
			sw_tick <= 1'b0;
			repeat (2) @(posedge ref_clk);
		end
		repeat (gap) @(posedge ref_clk);
	endtask
	task automatic cyc_en();
		en <= 1'b0;
		repeat (3) @(posedge ref_clk);
		en <= 1'b1;
		repeat (5) @(posedge ref_clk);
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (restart_req === 1'b1)
			restarts++;
		if (cyc == 80000) begin
			mismatches++;
			test_done();
		end
	end
	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (5) @(posedge ref_clk);
		rchk(8'h0C, 8'h00);
		rchk(8'h0D, 8'h00);
		rchk(8'h10, {MAKER, VER});
		chk(uv_trip_pct, 8'h32);
		for (int i = 0; i < 2; i++) begin
			wreg(8'h0B, {{4{i[0]}}, 4'h0});
			rchk(8'h0B, {{4{i[0]}}, 4'h0});
			chk(pg_rise_pct, i ? 8'h75 : 8'h70);
			chk(pg_rise_hys_pct, i ? 8'h06 : 8'h04);
			chk(pg_fall_pct, i ? 8'h55 : 8'h5A);
			chk(pg_fall_hys_pct, i ? 8'h06 : 8'h04);
		end
		for (int i = 0; i < 4; i++) begin
			wreg(8'h0E, {4'hF, i[1:0], i[1:0]});
			rchk(8'h0E, {1'b0, tj_range, i[1:0], i[1:0]});
			chk(thermal_trip_degc, TRIP[i]);
			chk(thermal_hys_degc, THYS[i]);
		end
		wreg(8'h0C, 8'h10);
		chk(uv_trip_pct, 8'h4B);
		wreg(8'h0D, 8'h02);
		chk({7'h00, feedback_connect_sel}, 8'h01);
		wreg(8'h0D, 8'h00);
		chk({7'h00, feedback_connect_sel}, 8'h00);
		wreg(8'h10, 8'h00);
		rchk(8'h10, {MAKER, VER});
		rchk(8'h20, 8'h00);
		u_host.wr(7'h21, 8'h0B, 8'hFF, ack);
		chk({7'h00, ack}, 8'h00);
		output_ok_cond <= 1'b1;
		vin_ov_cond <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk({7'h00, switch_en}, 8'h00);
		rchk(8'h0F, 8'h30);
		vin_ov_cond <= 1'b0;
		repeat (5) @(posedge ref_clk);
		chk({7'h00, switch_en}, 8'h01);
		rchk(8'h0F, 8'h20);
		wreg(8'h0C, 8'h80);
		ot_cond <= 1'b1;
		repeat (4) @(posedge ref_clk);
		ot_cond <= 1'b0;
		repeat (40) @(posedge ref_clk);
		rchk(8'h0F, 8'h21);
		cyc_en();
		rchk(8'h0F, 8'h20);
		wreg(8'h0C, 8'h00);
		wreg(8'h0B, 8'h04);
		oc_cond <= 1'b1;
		ticks(3, 0);
		chk({7'h00, switch_en}, 8'h01);
		ticks(1, 3);
		chk({6'h00, hiccup_active, switch_en}, 8'h02);
		oc_cond <= 1'b0;
		repeat (40) @(posedge ref_clk);
		chk({7'h00, switch_en}, 8'h00);
		repeat (20) @(posedge ref_clk);
		chk({7'h00, switch_en}, 8'h01);
		chk(8'(restarts), 8'h03);
		cyc_en();
		wreg(8'h0B, 8'h0C);
		wreg(8'h0C, 8'h05);
		uv_cond <= 1'b1;
		soft_start <= 1'b1;
		ticks(5, 0);
		chk({7'h00, latched_off}, 8'h00);
		soft_start <= 1'b0;
		ticks(3, 0);
		uv_cond <= 1'b0;
		@(posedge ref_clk);
		uv_cond <= 1'b1;
		ticks(3, 0);
		chk({7'h00, latched_off}, 8'h00);
		ticks(1, 3);
		uv_cond <= 1'b0;
		repeat (60) @(posedge ref_clk);
		chk({6'h00, latched_off, switch_en}, 8'h02);
		cyc_en();
		wreg(8'h0B, 8'h00);
		wreg(8'h0C, 8'h01);
		uv_cond <= 1'b1;
		oc_cond <= 1'b1;
		ticks(2, 3);
		chk({6'h00, latched_off, hiccup_active}, 8'h02);
		oc_cond <= 1'b0;
		cyc_en();
		wreg(8'h0C, 8'h02);
		oc_cond <= 1'b1;
		ticks(3, 3);
		chk({5'h00, hiccup_active, latched_off, switch_en}, 8'h01);
		uv_cond <= 1'b0;
		oc_cond <= 1'b0;
		wreg(8'h0B, 8'h01);
		oc_cond <= 1'b1;
		ticks(2, 3);
		chk({7'h00, latched_off}, 8'h01);
		oc_cond <= 1'b0;
		cyc_en();
		chk({6'h00, latched_off, switch_en}, 8'h01);
		wreg(8'h0D, 8'h01);
		vout_ov_cond <= 1'b1;
		ticks(2, 3);
		vout_ov_cond <= 1'b0;
		repeat (60) @(posedge ref_clk);
		chk({6'h00, latched_off, switch_en}, 8'h02);
		test_done();
	end
endmodule
